// *** rtl/odcd_host.sv ***
// Purpose: Host controller driving the display command decoder pins
// Assumes: 8-bit parallel bus, write latched on the rising write strobe
// Notes:   Software orders commands over Avalon-MM; all writes stall
//          while a transfer runs
// Functional notes
// - Column window two bytes, 0..159, reset 0/159
// - Row window two bytes, 0..131, reset 0/131
// - Write/read RAM mode lasts until next command
// - Three contrast bytes, reset 128 each
// - Master current factor four bits, reset 15
// - Second pre-charge speed two bits, reset normal
// - Start line and offset 0..131, reset 0
// - Multiplex byte must lie 15..131
// - Dim mode five bytes, first is zero
// - Phase one code zero is invalid
// - Phase two codes below two invalid
// - Gamma table 63 strictly increasing bytes
`timescale 1ns/1ns
`default_nettype none
module odcd_host
  import odcd_pkg::*;
#(
  parameter int P_RESET_CYC = T_RESET_CYC
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Avalon-MM slave
  input  wire logic [2:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Device bus
  output odcd_pins_t       o_pins,
  input  wire logic [7:0]  i_data
);

  localparam logic [15:0] STROBE_LD = 16'(T_STROBE_CYC - 1);
  localparam logic [15:0] RESET_LD  = 16'(P_RESET_CYC - 1);

  odcd_state_t state;
  odcd_pwr_t   pwr;
  odcd_ram_t   ram_mode;
  logic [15:0] tmr;
  logic [6:0]  idx;
  logic [6:0]  last;
  logic [7:0]  cmd;
  logic        is_pix;
  logic [31:0] arg;
  logic [7:0]  arg_e;
  logic [7:0]  pix_w;
  logic [7:0]  pix_r;
  logic [6:0]  g_prev;
  logic        err;
  logic        locked;
  logic [1:0]  disp_mode;
  logic [7:0]  remap;
  logic [7:0]  col_start;
  logic [7:0]  col_end;
  logic [7:0]  row_start;
  logic [7:0]  row_end;
  logic [7:0]  sync1;
  logic [7:0]  sync2;
  logic [7:0]  sync3;
  logic        rd_ack;
  logic [6:0]  g_rdata;

  // Bus decode
  // Writes keep stalling until the device reset pin has risen
  wire idle     = (state == S_IDLE) & o_pins.res_b;
  wire acc_w    = i_avs_write & idle;
  wire wr_ctrl  = acc_w & (i_avs_address == REG_CTRL);
  wire wr_arg   = acc_w & (i_avs_address == REG_ARG);
  wire wr_arg_e = acc_w & (i_avs_address == REG_ARG_E);
  wire wr_pix   = acc_w & (i_avs_address == REG_PIXEL);
  wire wr_gam   = acc_w & (i_avs_address == REG_GAMMA);
  wire wr_stat  = acc_w & (i_avs_address == REG_STATUS);
  wire wr_pixrd = acc_w & (i_avs_address == REG_PIXRD);
  wire rd_take  = i_avs_read & ~rd_ack;

  // Reads answer one edge later; writes stall until the engine is idle
  assign o_avs_waitrequest = rd_take | (i_avs_write & ~idle);

  // Order checks on the new command
  wire [7:0] op      = i_avs_writedata[7:0];
  wire [7:0] a0      = arg[7:0];
  wire [7:0] a1      = arg[15:8];
  wire [6:0] np      = odcd_nparams(op);
  wire       unk     = (np == NP_NONE);
  wire       col_bad = (op == CMD_COL) &
                       ((a0 > COL_MAX) | (a1 > COL_MAX) | (a0 > a1));
  wire       row_bad = (op == CMD_ROW) &
                       ((a0 > ROW_MAX) | (a1 > ROW_MAX) | (a0 > a1));
  wire       ln_bad  = ((op == CMD_START) | (op == CMD_OFFSET)) &
                       (a0 > ROW_MAX);
  wire       mux_bad = (op == CMD_MUX) &
                       ((a0 < MUX_MIN) | (a0 > ROW_MAX));
  wire       ph_bad  = (op == CMD_PHASE) &
                       ((a0[3:0] == 4'h0) | ({4'h0, a0[7:4]} < PH2_MIN));
  wire       lk_bad  = locked & (op != CMD_LOCK);
  wire       refuse  = unk | col_bad | row_bad | ln_bad | mux_bad | ph_bad |
                       lk_bad;
  wire       take    = wr_ctrl & ~refuse;
  wire       pix_ok  = ~locked & (ram_mode == RAM_WR);
  wire       prd_ok  = ~locked & (ram_mode == RAM_RD);
  wire       req_bad = (wr_ctrl & refuse) | (wr_pix & ~pix_ok) |
                       (wr_pixrd & ~prd_ok);

  // Gamma check: entry idx-1 is on the read port while idx runs 2..64
  wire [6:0] g_ent   = idx - 7'h01;
  wire [6:0] g_max   = (g_ent < 7'h08) ? 7'h0F :
                       (g_ent < 7'h10) ? 7'h1F :
                       (g_ent < 7'h20) ? 7'h3F : 7'h7F;
  wire       g_live  = (state == S_GCHK) & (idx >= 7'h02);
  wire       g_bad   = g_live & ((g_rdata <= g_prev) | (g_rdata > g_max));
  wire       g_done  = (state == S_GCHK) & (idx == (GAMMA_LAST + 7'h01));

  // Outgoing byte for the current position in the sequence
  wire [1:0] sel     = (cmd == CMD_DIM) ? 2'(idx - 7'h02) : 2'(idx - 7'h01);
  wire [7:0] p_raw   = (cmd == CMD_GAMMA) ? {1'b0, g_rdata} :
                       ((cmd == CMD_DIM) & (idx == 7'h01)) ? DIM_RSVD :
                       (idx == 7'h05) ? {3'h0, arg_e[4:0]} :
                       arg[{sel, 3'b000} +: 8];
  wire [7:0] p_mask  = p_raw & odcd_pmask(cmd);
  wire [7:0] p_byte  = (cmd == CMD_LOCK) ? (LOCK_BASE | p_mask) : p_mask;
  wire [7:0] cur     = is_pix ? pix_w : ((idx == 7'h00) ? cmd : p_byte);
  wire       cur_dc  = is_pix | (idx != 7'h00);
  wire       tmr_end = (tmr == 16'h0000);
  wire       in_ok   = (sync2 == sync3);
  wire [5:0] g_raddr = idx[5:0];

  odcd_gamma_mem u_gamma (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_we    (wr_gam),
    .i_waddr (i_avs_writedata[GW_IDX_LSB +: 6]),
    .i_wdata (i_avs_writedata[6:0]),
    .i_raddr (g_raddr),
    .o_rdata (g_rdata)
  );

  // Sequencer
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state  <= S_RESET;
      tmr    <= RESET_LD;
      idx    <= 7'h00;
      last   <= 7'h00;
      cmd    <= CMD_NOP;
      is_pix <= 1'b0;
      g_prev <= 7'h00;
    end
    else
    begin
      case (state)
        S_RESET:
        begin
          tmr <= tmr - 16'h0001;
          if (tmr_end)
          begin
            state <= S_IDLE;
          end
        end
        S_IDLE:
        begin
          idx    <= 7'h00;
          tmr    <= STROBE_LD;
          g_prev <= 7'h00;
          if (take)
          begin
            cmd    <= op;
            last   <= np;
            is_pix <= 1'b0;
            state  <= (op == CMD_GAMMA) ? S_GCHK : S_SETUP;
            idx    <= (op == CMD_GAMMA) ? 7'h01 : 7'h00;
          end
          else if (wr_pix & pix_ok)
          begin
            is_pix <= 1'b1;
            last   <= 7'h00;
            state  <= S_SETUP;
          end
          else if (wr_pixrd & prd_ok)
          begin
            state <= S_RDLOW;
          end
        end
        S_GCHK:
        begin
          idx <= idx + 7'h01;
          if (g_live)
          begin
            g_prev <= g_rdata;
          end
          if (g_bad)
          begin
            state <= S_IDLE;
          end
          else if (g_done)
          begin
            idx   <= 7'h00;
            state <= S_SETUP;
          end
        end
        S_SETUP, S_LOW, S_RDLOW:
        begin
          tmr <= tmr - 16'h0001;
          if (tmr_end & ((state != S_RDLOW) | in_ok))
          begin
            tmr   <= STROBE_LD;
            state <= (state == S_SETUP) ? S_LOW :
                     (state == S_LOW) ? S_HIGH : S_RDHIGH;
          end
        end
        S_HIGH, S_RDHIGH:
        begin
          tmr <= tmr - 16'h0001;
          if (tmr_end)
          begin
            tmr <= STROBE_LD;
            idx <= idx + 7'h01;
            state <= ((state == S_RDHIGH) | (idx == last)) ? S_IDLE : S_SETUP;
          end
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Pins come from flops; data is set up for a whole phase before the strobe, one cycle less for gamma table bytes
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pins <= '{res_b: 1'b0, cs_b: 1'b1, dc: 1'b0, wr_b: 1'b1,
                  rd_b: 1'b1, oe: 1'b0, data: 8'h00};
    end
    else
    begin
      o_pins.res_b <= (state != S_RESET);
      o_pins.cs_b  <= ~((state == S_SETUP) | (state == S_LOW) |
                        (state == S_HIGH) | (state == S_RDLOW) |
                        (state == S_RDHIGH));
      o_pins.wr_b  <= (state != S_LOW);
      o_pins.rd_b  <= (state != S_RDLOW);
      o_pins.oe    <= (state == S_SETUP) | (state == S_LOW) |
                      (state == S_HIGH);
      if (state == S_SETUP)
      begin
        o_pins.dc   <= cur_dc;
        o_pins.data <= cur;
      end
      else if (state == S_RDLOW)
      begin
        o_pins.dc <= 1'b1;
      end
    end
  end

  // Read data pass three flops; taken once the last two agree
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
      pix_r <= 8'h00;
    end
    else
    begin
      sync1 <= i_data;
      sync2 <= sync1;
      sync3 <= sync2;
      if ((state == S_RDLOW) & tmr_end & in_ok)
      begin
        pix_r <= sync3;
      end
    end
  end

  // Software-written staging
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      arg   <= 32'h0000_0000;
      arg_e <= 8'h00;
      pix_w <= 8'h00;
      err   <= 1'b0;
    end
    else
    begin
      if (wr_arg)
      begin
        arg <= i_avs_writedata;
      end
      if (wr_arg_e)
      begin
        arg_e <= i_avs_writedata[7:0];
      end
      if (wr_pix)
      begin
        pix_w <= i_avs_writedata[7:0];
      end
      // A refusal in the clearing cycle keeps the flag set
      if (req_bad | g_bad)
      begin
        err <= 1'b1;
      end
      else if (wr_stat & i_avs_writedata[ST_ERR_BIT])
      begin
        err <= 1'b0;
      end
    end
  end

  // Mirror of the device state the host has ordered
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      col_start <= 8'h00;
      col_end   <= COL_MAX;
      row_start <= 8'h00;
      row_end   <= ROW_MAX;
      locked    <= 1'b0;
      disp_mode <= MODE_RST;
      remap     <= 8'h40;
      pwr       <= PWR_OFF;
      ram_mode  <= RAM_NONE;
    end
    else if (take)
    begin
      ram_mode <= (op == CMD_RAM_WR) ? RAM_WR :
                  (op == CMD_RAM_RD) ? RAM_RD : RAM_NONE;
      case (op)
        CMD_COL:
        begin
          col_start <= a0;
          col_end   <= a1;
        end
        CMD_ROW:
        begin
          row_start <= a0;
          row_end   <= a1;
        end
        CMD_LOCK:    locked <= a0[LOCK_BIT];
        CMD_REMAP:   remap <= a0;
        CMD_ON_DIM:  pwr <= PWR_DIM;
        CMD_OFF:     pwr <= PWR_OFF;
        CMD_ON:      pwr <= PWR_ON;
        8'hA4, 8'hA5, 8'hA6, CMD_MODE_IV:
                     disp_mode <= op[1:0];
        CMD_SWRST:
        begin
          // Device display circuit restarts; assume window back to full
          col_start <= 8'h00;
          col_end   <= COL_MAX;
          row_start <= 8'h00;
          row_end   <= ROW_MAX;
        end
        default:     pwr <= pwr;
      endcase
    end
  end

  // Read data stand from the edge that drops waitrequest
  wire [31:0] rd_mux =
    (i_avs_address == REG_ARG)    ? arg :
    (i_avs_address == REG_ARG_E)  ? {24'h0, arg_e} :
    (i_avs_address == REG_PIXEL)  ? {24'h0, pix_r} :
    (i_avs_address == REG_WINDOW) ? {row_end, row_start, col_end, col_start} :
    (i_avs_address == REG_STATUS) ?
      {15'h0, remap, err, locked, 2'(pwr), disp_mode, 2'(ram_mode), ~idle} :
    32'h0000_0000;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rd_ack         <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      rd_ack <= rd_take;
      if (rd_take)
      begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

endmodule : odcd_host
`default_nettype wire

// *** rtl/odcd_pkg.sv ***
// Purpose: Shared constants and types for the display command host
// Assumes: 250 MHz system clock, 8-bit parallel device bus
// Notes:   Register offsets are word indexes on the Avalon slave
package odcd_pkg;

  // Timing
  localparam int CLK_NS        = 4;
  localparam int T_STROBE_NS   = 60;
  localparam int T_STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RESET_US    = 100;
  localparam int T_RESET_CYC   = (T_RESET_US * 1000 + CLK_NS - 1) / CLK_NS;

  // Avalon word indexes
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_ARG    = 3'h1;
  localparam logic [2:0] REG_ARG_E  = 3'h2;
  localparam logic [2:0] REG_PIXEL  = 3'h3;
  localparam logic [2:0] REG_GAMMA  = 3'h4;
  localparam logic [2:0] REG_WINDOW = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;
  localparam logic [2:0] REG_PIXRD  = 3'h7;

  // Field positions
  localparam int ST_ERR_BIT   = 9;
  localparam int GW_IDX_LSB   = 8;
  localparam int LOCK_BIT     = 2;

  // Command codes
  localparam logic [7:0] CMD_COL     = 8'h15;
  localparam logic [7:0] CMD_RAM_WR  = 8'h5C;
  localparam logic [7:0] CMD_RAM_RD  = 8'h5D;
  localparam logic [7:0] CMD_ROW     = 8'h75;
  localparam logic [7:0] CMD_CON_A   = 8'h81;
  localparam logic [7:0] CMD_CON_B   = 8'h82;
  localparam logic [7:0] CMD_CON_C   = 8'h83;
  localparam logic [7:0] CMD_MASTER  = 8'h87;
  localparam logic [7:0] CMD_PRE2SPD = 8'h8A;
  localparam logic [7:0] CMD_REMAP   = 8'hA0;
  localparam logic [7:0] CMD_START   = 8'hA1;
  localparam logic [7:0] CMD_OFFSET  = 8'hA2;
  localparam logic [7:0] CMD_MODE_NM = 8'hA4;
  localparam logic [7:0] CMD_MODE_IV = 8'hA7;
  localparam logic [7:0] CMD_MUX     = 8'hA8;
  localparam logic [7:0] CMD_DIM     = 8'hAB;
  localparam logic [7:0] CMD_ON_DIM  = 8'hAC;
  localparam logic [7:0] CMD_OFF     = 8'hAE;
  localparam logic [7:0] CMD_ON      = 8'hAF;
  localparam logic [7:0] CMD_PHASE   = 8'hB1;
  localparam logic [7:0] CMD_CLKDIV  = 8'hB3;
  localparam logic [7:0] CMD_PRE2LEN = 8'hB4;
  localparam logic [7:0] CMD_GAMMA   = 8'hB8;
  localparam logic [7:0] CMD_LINEAR  = 8'hB9;
  localparam logic [7:0] CMD_PRELVL  = 8'hBB;
  localparam logic [7:0] CMD_DESEL   = 8'hBE;
  localparam logic [7:0] CMD_SWRST   = 8'hE2;
  localparam logic [7:0] CMD_NOP     = 8'hE3;
  localparam logic [7:0] CMD_LOCK    = 8'hFD;

  // Limits and reset values
  localparam logic [7:0] COL_MAX     = 8'h9F;
  localparam logic [7:0] ROW_MAX     = 8'h83;
  localparam logic [7:0] MUX_MIN     = 8'h0F;
  localparam logic [7:0] PH2_MIN     = 8'h02;
  localparam logic [7:0] LOCK_BASE   = 8'h12;
  localparam logic [7:0] DIM_RSVD    = 8'h00;
  localparam logic [1:0] MODE_RST    = 2'h0;
  localparam logic [6:0] NP_NONE     = 7'h7F;
  localparam logic [6:0] GAMMA_LAST  = 7'h3F;

  typedef enum logic [1:0] {PWR_OFF, PWR_DIM, PWR_ON} odcd_pwr_t;
  typedef enum logic [1:0] {RAM_NONE, RAM_WR, RAM_RD} odcd_ram_t;
  typedef enum logic [2:0] {
    S_RESET, S_IDLE, S_GCHK, S_SETUP, S_LOW, S_HIGH, S_RDLOW, S_RDHIGH
  } odcd_state_t;

  // Device bus pins
  typedef struct packed {
    logic       res_b;
    logic       cs_b;
    logic       dc;
    logic       wr_b;
    logic       rd_b;
    logic       oe;
    logic [7:0] data;
  } odcd_pins_t;

  // Parameter bytes that follow each command code
  function automatic logic [6:0] odcd_nparams(input logic [7:0] c);
    case (c)
      CMD_COL, CMD_ROW:                         odcd_nparams = 7'h02;
      CMD_DIM:                                  odcd_nparams = 7'h05;
      CMD_GAMMA:                                odcd_nparams = GAMMA_LAST;
      CMD_CON_A, CMD_CON_B, CMD_CON_C, CMD_MASTER, CMD_PRE2SPD,
      CMD_REMAP, CMD_START, CMD_OFFSET, CMD_MUX, CMD_PHASE,
      CMD_CLKDIV, CMD_PRE2LEN, CMD_PRELVL, CMD_DESEL, CMD_LOCK:
                                                odcd_nparams = 7'h01;
      CMD_RAM_WR, CMD_RAM_RD, 8'hA4, 8'hA5, 8'hA6, CMD_MODE_IV,
      CMD_ON_DIM, CMD_OFF, CMD_ON, CMD_LINEAR, CMD_SWRST, CMD_NOP:
                                                odcd_nparams = 7'h00;
      default:                                  odcd_nparams = NP_NONE;
    endcase
  endfunction : odcd_nparams

  // Don't-care bits of a single parameter are sent as zero
  function automatic logic [7:0] odcd_pmask(input logic [7:0] c);
    case (c)
      CMD_MASTER, CMD_PRE2LEN: odcd_pmask = 8'h0F;
      CMD_PRE2SPD:             odcd_pmask = 8'h03;
      CMD_PRELVL:              odcd_pmask = 8'h3E;
      CMD_DESEL:               odcd_pmask = 8'h3C;
      CMD_LOCK:                odcd_pmask = 8'h04;
      default:                 odcd_pmask = 8'hFF;
    endcase
  endfunction : odcd_pmask

endpackage : odcd_pkg

// *** rtl/odcd_gamma_mem.sv ***
// Purpose: Gray-level table staging memory, 64 x 7 bits
// Assumes: One write and one read port on the same clock
// Notes:   Read data are registered, one cycle behind the address
`timescale 1ns/1ns
`default_nettype none
module odcd_gamma_mem
  import odcd_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Write port
  input  wire logic       i_we,
  input  wire logic [5:0] i_waddr,
  input  wire logic [6:0] i_wdata,
  // Read port
  input  wire logic [5:0] i_raddr,
  output logic      [6:0] o_rdata
);

  logic [6:0] mem [64];

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rdata <= 7'h00;
    end
    else
    begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule : odcd_gamma_mem
`default_nettype wire

// *** bench/odcd_dev_model.sv ***
// Purpose: Behavioural display device on the host pin bus
// Assumes: Bytes latch on the rising write strobe
// Notes:   Logs each accepted byte as {dc, data} for the bench
`timescale 1ns/1ns
`default_nettype none
module odcd_dev_model
  import odcd_pkg::*;
(
  // Pins from the host
  input  wire odcd_pins_t i_pins,
  // Read data back
  output logic [7:0]      o_data
);
  logic [8:0] log_q[$];
  logic       locked   = 1'b0;
  logic       lock_arg = 1'b0;
  logic       rd_mode  = 1'b0;
  logic [7:0] pix      = 8'h5A;
  initial o_data = 8'hA5;
  // Codes and parameters stored as sent
  always @(posedge i_pins.wr_b)
    if (!i_pins.cs_b)
    begin
      if (!locked || lock_arg || i_pins.data == CMD_LOCK)
        log_q.push_back({i_pins.dc, i_pins.data});
      if (lock_arg && i_pins.dc)
        locked = i_pins.data[LOCK_BIT];
      if (!i_pins.dc)
      begin
        lock_arg = (i_pins.data == CMD_LOCK);
        rd_mode  = (i_pins.data == CMD_RAM_RD);
      end
    end
  // Released bus flips so a stale byte never reads as valid
  always @(i_pins.rd_b or i_pins.cs_b)
    o_data = (!i_pins.rd_b && !i_pins.cs_b && rd_mode) ? pix : ~o_data;
  // Only a finished read moves the pointer, never the reset edge
  always @(posedge i_pins.rd_b)
    if (!i_pins.cs_b && rd_mode)
      pix <= pix + 8'h01;
endmodule : odcd_dev_model
`default_nettype wire

// *** bench/odcd_host_checker.sv ***
// Purpose: Pin and bus protocol checker for the display command host
// Assumes: One clock, async active-low reset
// Notes:   Each strobe phase is 15 cycles
`timescale 1ns/1ns
`default_nettype none
module odcd_host_checker
  import odcd_pkg::*;
#(
  parameter int P_RESET_CYC = T_RESET_CYC
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Avalon-MM slave
  input  wire logic [2:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [31:0] o_avs_readdata,
  input  wire logic        o_avs_waitrequest,
  // Device bus
  input  wire odcd_pins_t  o_pins,
  input  wire logic [7:0]  i_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  int unsigned res_cnt;
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      res_cnt <= 0;
    else if (!o_pins.res_b)
      res_cnt <= res_cnt + 1;
  sequence s_setup;
    o_pins.wr_b [*8] ##1 o_pins.wr_b [*7] ##1 !o_pins.wr_b;
  endsequence
  sequence s_low;
    !o_pins.wr_b [*8] ##1 !o_pins.wr_b [*7] ##1 o_pins.wr_b;
  endsequence
  chk_setup_len:
    assert property ($fell(o_pins.cs_b) && o_pins.rd_b |-> s_setup)
    else $error("setup phase length wrong");
  chk_strobe_len:
    assert property ($fell(o_pins.wr_b) |-> s_low)
    else $error("write strobe length wrong");
  chk_byte_hold:
    assert property (!o_pins.wr_b |-> $stable(o_pins.data) && $stable(o_pins.dc))
    else $error("byte moved under strobe");
  chk_strobe_sel:
    assert property (!o_pins.wr_b || !o_pins.rd_b || o_pins.oe |-> !o_pins.cs_b)
    else $error("strobe without select");
  chk_read_dir:
    assert property (!o_pins.rd_b |-> !o_pins.oe && o_pins.dc && o_pins.wr_b)
    else $error("read phase drives bus");
  chk_res_hold:
    assert property ($rose(o_pins.res_b) |-> res_cnt >= P_RESET_CYC - 1)
    else $error("device reset too short");
  chk_read_wait:
    assert property ($rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("read answer late");
  chk_write_stall:
    assert property (i_avs_write && (!o_pins.wr_b || !o_pins.res_b)
                     |-> o_avs_waitrequest)
    else $error("write taken while busy");
  chk_rdata_hold:
    assert property ($changed(o_avs_readdata) |-> i_avs_read && !o_avs_waitrequest)
    else $error("read data moved");
endmodule : odcd_host_checker
bind odcd_host odcd_host_checker #(.P_RESET_CYC(P_RESET_CYC)) odcd_host_checker_i (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_pins(o_pins), .i_data(i_data));
`default_nettype wire

// *** bench/odcd_host_tb.sv ***
// Purpose: Self-checking bench for the display command host
// Assumes: Device model logs every byte it latches, bar non-lock bytes while locked
// Notes:   Short device reset of 20 cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module odcd_host_tb
  import odcd_pkg::*;
;
  logic        i_clk, rd, wr, wait_req;
  logic        i_rst_b;
  logic [2:0]  adr;
  logic [31:0] wdat, rdat, st;
  odcd_pins_t  pins;
  logic [7:0]  dev_data, bus;
  logic [8:0]  exp_q[$];
  int          bad_count = 0, n_tests = 0, cyc = 0;
  assign bus = pins.oe ? pins.data : dev_data;
  odcd_host #(.P_RESET_CYC(20)) odcd_host_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wait_req),
    .o_pins(pins), .i_data(bus));
  odcd_dev_model odcd_dev_model_i (.i_pins(pins), .o_data(dev_data));
  task automatic av_wr(input logic [2:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    while (wait_req !== 1'b0) @(posedge i_clk);
    wr <= 1'b0;
    @(posedge i_clk);
  endtask : av_wr
  task automatic av_rd(input logic [2:0] a, output logic [31:0] r);
    adr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    while (wait_req !== 1'b0) @(posedge i_clk);
    r = rdat;
    rd <= 1'b0;
    @(posedge i_clk);
  endtask : av_rd
  // Waits on busy so the next order never stalls mid-check
  task automatic order(input logic [2:0] a, input logic [31:0] d);
    av_wr(a, d);
    st = 32'h1;
    while (st[0] !== 1'b0) av_rd(REG_STATUS, st);
  endtask : order
  task automatic cmd(input logic [7:0] c, input logic [7:0] p, input bit ok);
    order(REG_ARG, {24'h0, p});
    order(REG_CTRL, {24'h0, c});
    if (ok) exp_q.push_back({1'b0, c});
  endtask : cmd
  task automatic match();
    `CHK(odcd_dev_model_i.log_q.size(), exp_q.size())
    foreach (exp_q[i]) `CHK(odcd_dev_model_i.log_q[i], exp_q[i])
    exp_q.delete();
    odcd_dev_model_i.log_q.delete();
  endtask : match
  task automatic err_set();
    av_rd(REG_STATUS, st);
    `CHK(st[8], 1'b1)
    order(REG_STATUS, 32'h200);
  endtask : err_set
  task automatic t_reset();
    st = 32'h1;
    while (st[0] !== 1'b0) av_rd(REG_STATUS, st);
    av_rd(REG_WINDOW, st);
    `CHK(st, 32'h8300_9F00)
    av_rd(REG_STATUS, st);
    `CHK(st, 32'h0000_8000)
  endtask : t_reset
  task automatic t_window();
    cmd(CMD_COL, 8'h02, 1'b0);
    err_set();
    order(REG_ARG, 32'h9D02);
    order(REG_CTRL, 32'h15);
    exp_q = '{9'h015, 9'h102, 9'h19D, 9'h075, 9'h101, 9'h182};
    order(REG_ARG, 32'h8201);
    order(REG_CTRL, 32'h75);
    match();
    av_rd(REG_WINDOW, st);
    `CHK(st, 32'h8201_9D02)
    order(REG_ARG, 32'hA005);
    order(REG_CTRL, 32'h15);
    err_set();
    order(REG_ARG, 32'h8400);
    order(REG_CTRL, 32'h75);
    err_set();
    match();
    cmd(CMD_SWRST, 8'h00, 1'b1);
    match();
    av_rd(REG_WINDOW, st);
    `CHK(st, 32'h8300_9F00)
  endtask : t_window
  task automatic t_params();
    logic [23:0] good [16] = '{24'h81AAAA, 24'h825555, 24'h830000,
      24'h87FF0F, 24'h8AFF03, 24'hA0C5C5, 24'hA18383, 24'hA20000,
      24'hA80F0F, 24'hA88383, 24'hB12121, 24'hB1FFFF, 24'hB3C0C0,
      24'hB4FF0F, 24'hBBFF3E, 24'hBEFF3C};
    logic [15:0] bad [6] = '{16'hA80E, 16'hB120, 16'hB114, 16'hA184,
      16'hA284, 16'h2100};
    foreach (good[i])
    begin
      cmd(good[i][23:16], good[i][15:8], 1'b1);
      exp_q.push_back({1'b1, good[i][7:0]});
    end
    match();
    av_rd(REG_STATUS, st);
    `CHK(st[16:9], 8'hC5)
    foreach (bad[i])
    begin
      cmd(bad[i][15:8], bad[i][7:0], 1'b0);
      err_set();
    end
    match();
  endtask : t_params
  task automatic t_modes();
    logic [7:0] c [9] = '{8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hAC, 8'hAE, 8'hAF,
      8'hB9, 8'hE3};
    foreach (c[i])
    begin
      cmd(c[i], 8'h00, 1'b1);
      av_rd(REG_STATUS, st);
      if (i < 4) `CHK(st[4:3], c[i][1:0])
      if (i == 4) `CHK(st[6:5], 2'h1)
      if (i == 5) `CHK(st[6:5], 2'h0)
      if (i == 6) `CHK(st[6:5], 2'h2)
    end
    match();
  endtask : t_modes
  task automatic t_dim();
    order(REG_ARG, 32'h0033_2211);
    order(REG_ARG_E, 32'h1F);
    order(REG_CTRL, 32'hAB);
    exp_q = '{9'h0AB, 9'h100, 9'h111, 9'h122, 9'h133, 9'h11F};
    match();
  endtask : t_dim
  task automatic t_ram();
    cmd(CMD_RAM_WR, 8'h00, 1'b1);
    order(REG_PIXEL, 32'h3C);
    exp_q.push_back(9'h13C);
    av_rd(REG_STATUS, st);
    `CHK(st[2:1], 2'h1)
    order(REG_PIXRD, 32'h0);
    err_set();
    cmd(CMD_RAM_RD, 8'h00, 1'b1);
    order(REG_PIXRD, 32'h0);
    av_rd(REG_PIXEL, st);
    `CHK(st[7:0], 8'h5A)
    order(REG_PIXRD, 32'h0);
    av_rd(REG_PIXEL, st);
    `CHK(st[7:0], 8'h5B)
    order(REG_PIXEL, 32'h77);
    err_set();
    match();
  endtask : t_ram
  task automatic t_gamma();
    logic [6:0] v;
    exp_q.push_back(9'h0B8);
    for (int i = 1; i < 64; i++)
    begin
      v = (i < 32) ? 7'(2 * i) : 7'(2 * i + 1);
      order(REG_GAMMA, {18'h0, 6'(i), 1'b0, v});
      exp_q.push_back({2'b10, v});
    end
    order(REG_CTRL, 32'hB8);
    match();
    order(REG_GAMMA, 32'h0508);
    order(REG_CTRL, 32'hB8);
    err_set();
    match();
  endtask : t_gamma
  task automatic t_lock();
    cmd(CMD_LOCK, 8'h04, 1'b1);
    exp_q.push_back(9'h116);
    av_rd(REG_STATUS, st);
    `CHK(st[7], 1'b1)
    cmd(CMD_CON_A, 8'h01, 1'b0);
    err_set();
    cmd(CMD_LOCK, 8'h00, 1'b1);
    exp_q.push_back(9'h112);
    match();
    av_rd(REG_STATUS, st);
    `CHK(st[7], 1'b0)
  endtask : t_lock
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  initial
  begin
    i_rst_b = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 3'h0;
    wdat = 32'h0;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_window();
    t_params();
    t_modes();
    t_dim();
    t_ram();
    t_gamma();
    t_lock();
    give_verdict();
  end
endmodule : odcd_host_tb
`default_nettype wire
